// File: verilog/dslc_defines.svh
// Purpose: register offsets, field positions, reset values and codes for the label codec controller
// Assumes: byte addresses on the register port, one 32-bit word each
// Notes: definitions only
`ifndef DSLC_DEFINES_SVH
`define DSLC_DEFINES_SVH

`define DSLC_A_CTRL      8'h00
`define DSLC_A_DEST      8'h04
`define DSLC_A_ORIG      8'h08
`define DSLC_A_BEARER    8'h0C
`define DSLC_A_SLOT      8'h10
`define DSLC_A_HEAD      8'h14
`define DSLC_A_STATUS    8'h18
`define DSLC_A_RX_DEST   8'h1C
`define DSLC_A_RX_ORIG   8'h20
`define DSLC_A_RX_BEARER 8'h24
`define DSLC_A_RX_MISC   8'h28

`define DSLC_C_START     0
`define DSLC_C_FACIL     1
`define DSLC_C_ALT       2
`define DSLC_C_NATL      3
`define DSLC_C_FULL      4
`define DSLC_C_SEC       5
`define DSLC_C_RATE_LO   6
`define DSLC_C_RX_ALT    8
`define DSLC_C_RX_SEC    9

`define DSLC_CTRL_RST    10'h000
`define DSLC_SI_CALL     4'h6
`define DSLC_SI_FACIL    4'h7
`define DSLC_NI_INTL     2'h0
`define DSLC_NI_SPARE    2'h1
`define DSLC_NI_NATL     2'h2
`define DSLC_SLOT_FULL   8'h70
`define DSLC_PHASE_MAX   3'h4

`define DSLC_LEN_BASIC   7'h3C
`define DSLC_LEN_ALT     7'h34
`define DSLC_LEN_FACIL   7'h2C
`define DSLC_LEN_SEC     7'h04

`define DSLC_H_ADDR      4'h1
`define DSLC_H_ACCEPT    4'h4
`define DSLC_H_REJECT    4'h5
`define DSLC_H_CLEAR     4'h6
`define DSLC_H_STATE     4'h7

`endif

// File: verilog/dslc_pkg.sv
// Purpose: types shared by the label codec controller
// Assumes: nothing
// Notes: constants live in dslc_defines.svh
package dslc_pkg;

	typedef enum logic [1:0]
	{
		DSLC_IDLE = 2'b01,
		DSLC_SEND = 2'b10
	} dslc_state_t;

	typedef enum logic [2:0]
	{
		DSLC_HK_SPARE  = 3'h0,
		DSLC_HK_ADDR   = 3'h1,
		DSLC_HK_ACCEPT = 3'h2,
		DSLC_HK_REJECT = 3'h3,
		DSLC_HK_CLEAR  = 3'h4,
		DSLC_HK_STATE  = 3'h5
	} dslc_head_kind_t;

	typedef struct packed
	{
		logic [13:0] destination_point_code;
		logic [13:0] origin_point_code;
		logic [11:0] bearer_code;
		logic [7:0]  slot_channel_code;
	} dslc_label_t;

	typedef struct packed
	{
		logic [3:0] secondary_heading_code;
		logic [3:0] primary_heading_code;
	} dslc_head_t;

endpackage

// File: verilog/dslc_ctrl.sv
// Purpose: builds and parses the service octet, label and heading of data signalling messages
// Assumes: link pins synchronous to clk; peer keeps the same coding on its side
// Notes: bits go out and come in least significant first, service octet first
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "dslc_defines.svh"

module dslc_ctrl
#(
	parameter int DATA_W = 32
)
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              tx_ready,
	output logic                   tx_bit,
	output logic                   tx_bit_valid,
	output logic                   tx_first,
	output logic                   tx_last,
	output logic                   tx_msu,
	input  wire logic              rx_bit,
	input  wire logic              rx_bit_valid,
	input  wire logic              rx_last,
	input  wire logic              rx_msu
);

	function automatic dslc_pkg::dslc_head_kind_t head_kind(input logic [3:0] h);
		unique case (h)
			`DSLC_H_ADDR:   head_kind = dslc_pkg::DSLC_HK_ADDR;
			`DSLC_H_ACCEPT: head_kind = dslc_pkg::DSLC_HK_ACCEPT;
			`DSLC_H_REJECT: head_kind = dslc_pkg::DSLC_HK_REJECT;
			`DSLC_H_CLEAR:  head_kind = dslc_pkg::DSLC_HK_CLEAR;
			`DSLC_H_STATE:  head_kind = dslc_pkg::DSLC_HK_STATE;
			default:        head_kind = dslc_pkg::DSLC_HK_SPARE;
		endcase
	endfunction

	dslc_pkg::dslc_state_t     state_r;
	logic [9:0]                ctrl_r;
	dslc_pkg::dslc_label_t     cfg_r;
	dslc_pkg::dslc_head_t      head_r;
	logic [63:0]               shift_r;
	logic [63:0]               shift_nxt;
	logic [6:0]                len_r;
	logic [6:0]                len_nxt;
	logic [6:0]                idx_r;
	logic                      cfg_err_r;
	logic                      cfg_ok;
	logic [7:0]                slot_nxt;
	logic [7:0]                sio_nxt;
	logic [3:0]                chan_max;
	logic                      start;
	logic                      sel_ctrl;
	logic [63:0]               rx_buf_r;
	logic [6:0]                rx_idx_r;
	logic                      rx_done_r;
	logic                      rx_err_r;
	logic [7:0]                rx_sio_r;
	dslc_pkg::dslc_label_t     rx_lab_r;
	dslc_pkg::dslc_head_t      rx_head_r;
	logic [63:0]               rx_full;
	logic                      rx_bad;
	logic [DATA_W-1:0]         rd_nxt;

	assign sel_ctrl = reg_wr && (reg_addr == `DSLC_A_CTRL);
	assign start    = sel_ctrl && reg_wdata[`DSLC_C_START] && (state_r == dslc_pkg::DSLC_IDLE);

	// channel ceiling by rate: 0 600, 1 2400, 2 4800, 3 9600 bit/s
	always_comb
	begin
		unique case (reg_wdata[`DSLC_C_RATE_LO+1:`DSLC_C_RATE_LO])
			2'h0:    chan_max = 4'hF;
			2'h1:    chan_max = 4'h3;
			2'h2:    chan_max = 4'h1;
			default: chan_max = 4'h0;
		endcase
	end

	// slot code and service octet built from the start command and stored fields
	always_comb
	begin
		if (reg_wdata[`DSLC_C_FULL])
			slot_nxt = `DSLC_SLOT_FULL;
		else
			slot_nxt = {1'b0, cfg_r.slot_channel_code[6:4], cfg_r.slot_channel_code[3:0]};
		sio_nxt[3:0] = reg_wdata[`DSLC_C_FACIL] ? `DSLC_SI_FACIL : `DSLC_SI_CALL;
		sio_nxt[5:4] = 2'h0;
		sio_nxt[7:6] = reg_wdata[`DSLC_C_NATL] ? `DSLC_NI_NATL : `DSLC_NI_INTL;
	end

	// refuse a start whose slot or label choice breaks the coding ranges
	always_comb
	begin
		cfg_ok = 1'b1;
		if (!reg_wdata[`DSLC_C_FULL] && !reg_wdata[`DSLC_C_FACIL])
		begin
			if (cfg_r.slot_channel_code[6:4] > `DSLC_PHASE_MAX)
				cfg_ok = 1'b0;
			if (cfg_r.slot_channel_code[3:0] > chan_max)
				cfg_ok = 1'b0;
			if (reg_wdata[`DSLC_C_ALT])
				cfg_ok = 1'b0;
		end
	end

	// frame image, first bit in position zero
	always_comb
	begin
		shift_nxt = 64'h0;
		shift_nxt[7:0] = sio_nxt;
		shift_nxt[21:8]  = cfg_r.destination_point_code;
		shift_nxt[35:22] = cfg_r.origin_point_code;
		if (reg_wdata[`DSLC_C_FACIL])
		begin
			shift_nxt[39:36] = cfg_r.bearer_code[3:0];
			shift_nxt[43:40] = head_r.primary_heading_code;
			shift_nxt[47:44] = head_r.secondary_heading_code;
			len_nxt = `DSLC_LEN_FACIL;
		end
		else if (reg_wdata[`DSLC_C_ALT])
		begin
			shift_nxt[47:36] = cfg_r.bearer_code;
			shift_nxt[51:48] = head_r.primary_heading_code;
			shift_nxt[55:52] = head_r.secondary_heading_code;
			len_nxt = `DSLC_LEN_ALT;
		end
		else
		begin
			shift_nxt[47:36] = cfg_r.bearer_code;
			shift_nxt[55:48] = slot_nxt;
			shift_nxt[59:56] = head_r.primary_heading_code;
			shift_nxt[63:60] = head_r.secondary_heading_code;
			len_nxt = `DSLC_LEN_BASIC;
		end
		if (reg_wdata[`DSLC_C_SEC])
			len_nxt = len_nxt + `DSLC_LEN_SEC;
	end

	// software registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_r <= `DSLC_CTRL_RST;
			cfg_r  <= '0;
			head_r <= '0;
		end
		else if (ce && reg_wr)
		begin
			unique case (reg_addr)
				`DSLC_A_CTRL:   ctrl_r <= {reg_wdata[9:1], 1'b0};
				`DSLC_A_DEST:   cfg_r.destination_point_code <= reg_wdata[13:0];
				`DSLC_A_ORIG:   cfg_r.origin_point_code <= reg_wdata[13:0];
				`DSLC_A_BEARER: cfg_r.bearer_code <= reg_wdata[11:0];
				`DSLC_A_SLOT:   cfg_r.slot_channel_code <= {1'b0, reg_wdata[6:0]};
				`DSLC_A_HEAD:   head_r <= reg_wdata[7:0];
				default:        ;
			endcase
		end
	end

	// transmit sequencer
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r   <= dslc_pkg::DSLC_IDLE;
			shift_r   <= 64'h0;
			len_r     <= 7'h0;
			idx_r     <= 7'h0;
			cfg_err_r <= 1'b0;
		end
		else if (ce)
		begin
			unique case (state_r)
				dslc_pkg::DSLC_IDLE:
				begin
					if (start)
					begin
						cfg_err_r <= !cfg_ok;
						if (cfg_ok)
						begin
							state_r <= dslc_pkg::DSLC_SEND;
							shift_r <= shift_nxt;
							len_r   <= len_nxt;
							idx_r   <= 7'h0;
						end
					end
				end
				dslc_pkg::DSLC_SEND:
				begin
					if (tx_ready)
					begin
						shift_r <= {1'b0, shift_r[63:1]};
						idx_r   <= idx_r + 7'h1;
						if (idx_r == len_r - 7'h1)
							state_r <= dslc_pkg::DSLC_IDLE;
					end
				end
			endcase
		end
	end

	// link pins, all registered
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_bit       <= 1'b0;
			tx_bit_valid <= 1'b0;
			tx_first     <= 1'b0;
			tx_last      <= 1'b0;
			tx_msu       <= 1'b0;
		end
		else if (ce)
		begin
			tx_bit_valid <= (state_r == dslc_pkg::DSLC_SEND) && tx_ready;
			tx_bit       <= (state_r == dslc_pkg::DSLC_SEND) && tx_ready && shift_r[0];
			tx_first     <= (state_r == dslc_pkg::DSLC_SEND) && tx_ready && (idx_r == 7'h0);
			tx_last      <= (state_r == dslc_pkg::DSLC_SEND) && tx_ready && (idx_r == len_r - 7'h1);
			tx_msu       <= (state_r == dslc_pkg::DSLC_SEND);
		end
	end

	// receive image including the bit of this cycle
	always_comb
	begin
		rx_full = rx_buf_r;
		if (!rx_idx_r[6])
			rx_full[rx_idx_r[5:0]] = rx_bit;
		rx_bad = !rx_msu;
		if ((rx_full[3:0] != `DSLC_SI_CALL) && (rx_full[3:0] != `DSLC_SI_FACIL))
			rx_bad = 1'b1;
		if (rx_full[7:6] == `DSLC_NI_SPARE)
			rx_bad = 1'b1;
	end

	// receive parser; bits A and B and national-only bits are not interpreted
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_buf_r  <= 64'h0;
			rx_idx_r  <= 7'h0;
			rx_done_r <= 1'b0;
			rx_err_r  <= 1'b0;
			rx_sio_r  <= 8'h0;
			rx_lab_r  <= '0;
			rx_head_r <= '0;
		end
		else if (ce)
		begin
			if (rx_bit_valid && rx_last)
			begin
				rx_buf_r  <= 64'h0;
				rx_idx_r  <= 7'h0;
				rx_done_r <= 1'b1;
				rx_err_r  <= rx_bad;
				rx_sio_r  <= {rx_full[7:6], 2'h0, rx_full[3:0]};
				rx_lab_r.destination_point_code <= rx_full[21:8];
				rx_lab_r.origin_point_code      <= rx_full[35:22];
				if (rx_full[3:0] == `DSLC_SI_FACIL)
				begin
					rx_lab_r.bearer_code       <= {8'h00, rx_full[39:36]};
					rx_lab_r.slot_channel_code <= 8'h00;
					rx_head_r <= {rx_full[47:44] & {4{ctrl_r[`DSLC_C_RX_SEC]}}, rx_full[43:40]};
				end
				else if (ctrl_r[`DSLC_C_RX_ALT])
				begin
					rx_lab_r.bearer_code       <= rx_full[47:36];
					rx_lab_r.slot_channel_code <= `DSLC_SLOT_FULL;
					rx_head_r <= {rx_full[55:52] & {4{ctrl_r[`DSLC_C_RX_SEC]}}, rx_full[51:48]};
				end
				else
				begin
					rx_lab_r.bearer_code       <= rx_full[47:36];
					rx_lab_r.slot_channel_code <= rx_full[55:48];
					rx_head_r <= {rx_full[63:60] & {4{ctrl_r[`DSLC_C_RX_SEC]}}, rx_full[59:56]};
				end
			end
			else
			begin
				if (rx_bit_valid && (rx_idx_r < 7'h40))
				begin
					rx_buf_r <= rx_full;
					rx_idx_r <= rx_idx_r + 7'h1;
				end
				if (reg_rd && (reg_addr == `DSLC_A_STATUS))
					rx_done_r <= 1'b0;
			end
		end
	end

	// read mux
	always_comb
	begin
		rd_nxt = '0;
		unique case (reg_addr)
			`DSLC_A_CTRL:      rd_nxt[9:0] = ctrl_r;
			`DSLC_A_DEST:      rd_nxt[13:0] = cfg_r.destination_point_code;
			`DSLC_A_ORIG:      rd_nxt[13:0] = cfg_r.origin_point_code;
			`DSLC_A_BEARER:    rd_nxt[11:0] = cfg_r.bearer_code;
			`DSLC_A_SLOT:      rd_nxt[7:0] = cfg_r.slot_channel_code;
			`DSLC_A_HEAD:      rd_nxt[7:0] = head_r;
			`DSLC_A_STATUS:    rd_nxt[6:0] = {head_kind(rx_head_r.primary_heading_code), rx_err_r, rx_done_r,
			                                  cfg_err_r, (state_r == dslc_pkg::DSLC_SEND)};
			`DSLC_A_RX_DEST:   rd_nxt[13:0] = rx_lab_r.destination_point_code;
			`DSLC_A_RX_ORIG:   rd_nxt[13:0] = rx_lab_r.origin_point_code;
			`DSLC_A_RX_BEARER: rd_nxt[11:0] = rx_lab_r.bearer_code;
			`DSLC_A_RX_MISC:   rd_nxt[23:0] = {rx_sio_r, rx_head_r, rx_lab_r.slot_channel_code};
			default:           rd_nxt = '0;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= '0;
		else if (ce)
			reg_rdata <= reg_rd ? rd_nxt : '0;
	end

endmodule // dslc_ctrl

// File: testbench/dslc_ctrl_assertions.sv
// Purpose: port checks for the label codec controller
// Assumes: ce held high, so each pin pulse is one bit
// Notes: bind after the module
`timescale 1ns/1ps
module dslc_ctrl_checker
#(
	parameter int DATA_W = 32
)
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              tx_ready,
	input wire logic              tx_bit,
	input wire logic              tx_bit_valid,
	input wire logic              tx_first,
	input wire logic              tx_last,
	input wire logic              tx_msu
);
	logic [6:0] cnt_r;
	logic [6:0] idx;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// position of the bit now on the pins
	assign idx = tx_first ? 7'h00 : cnt_r;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt_r <= 7'h00;
		else if (tx_bit_valid)
			cnt_r <= idx + 7'h01;
	end
	a_bit_needs_ready: assert property (tx_bit_valid |-> $past(tx_ready))
		else $error("bit sent without ready");
	a_msu_only: assert property (tx_bit_valid |-> tx_msu)
		else $error("bit sent outside a message unit");
	a_first_is_bit: assert property (tx_first |-> tx_bit_valid)
		else $error("first flag without bit");
	a_si_ones: assert property (tx_bit_valid && (idx == 7'h01 || idx == 7'h02) |-> tx_bit)
		else $error("service indicator bit B or C wrong");
	a_si_top: assert property (tx_bit_valid && idx == 7'h03 |-> !tx_bit)
		else $error("service indicator bit D wrong");
	a_spare_zero: assert property (tx_bit_valid && (idx == 7'h04 || idx == 7'h05) |-> !tx_bit)
		else $error("subservice spare bit not zero");
	a_ni_low: assert property (tx_bit_valid && idx == 7'h06 |-> !tx_bit)
		else $error("national indicator low bit set");
	a_frame_len: assert property (tx_last |-> tx_bit_valid && idx inside {7'h2B, 7'h2F, 7'h33, 7'h37, 7'h3B, 7'h3F})
		else $error("frame length wrong");
	a_gap_after: assert property (tx_last |=> !tx_bit_valid [*2])
		else $error("bits right after frame end");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside read cycle");
endmodule // dslc_ctrl_checker

bind dslc_ctrl dslc_ctrl_checker #(.DATA_W(DATA_W)) dslc_ctrl_checker_inst (.clk(clk), .sys_rst(sys_rst),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_ready(tx_ready), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
	.tx_first(tx_first), .tx_last(tx_last), .tx_msu(tx_msu));

// File: testbench/dslc_peer.sv
// Purpose: peer transfer layer: takes sent bits, sends frames back
// Assumes: frames of at most 64 bits
// Notes: slow halves the ready rate
`timescale 1ns/1ps
module dslc_peer
(
	input wire logic  clk,
	input wire logic  sys_rst,
	input wire logic  slow,
	input wire logic  tx_bit,
	input wire logic  tx_bit_valid,
	input wire logic  tx_first,
	input wire logic  tx_last,
	output logic        tx_ready,
	output logic        rx_bit,
	output logic        rx_bit_valid,
	output logic        rx_last,
	output logic        rx_msu,
	output logic [63:0] frame,
	output logic [6:0]  frame_len,
	output logic [7:0]  n_frames
);
	logic [6:0] cnt_r;
	initial
	begin
		rx_bit = 1'h0;
		rx_bit_valid = 1'h0;
		rx_last = 1'h0;
		rx_msu = 1'h0;
	end
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			tx_ready <= 1'h0;
		else
			tx_ready <= slow ? ~tx_ready : 1'h1;
	end
	// collect bits, first one at index 0
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_r <= 7'h00;
			frame <= 64'h0;
			frame_len <= 7'h00;
			n_frames <= 8'h00;
		end
		else if (tx_bit_valid)
		begin
			if (tx_first)
				frame <= {63'h0, tx_bit};
			else
				frame[cnt_r[5:0]] <= tx_bit;
			cnt_r <= tx_first ? 7'h01 : cnt_r + 7'h01;
			if (tx_last)
			begin
				frame_len <= tx_first ? 7'h01 : cnt_r + 7'h01;
				n_frames <= n_frames + 8'h01;
			end
		end
	end
	// least significant bit first, unit type on rx_msu
	task automatic send(input logic [63:0] f, input int n, input logic msu);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			rx_bit <= f[i];
			rx_bit_valid <= 1'h1;
			rx_last <= (i == n - 1);
			rx_msu <= msu;
		end
		@(posedge clk);
		rx_bit <= ~rx_bit;
		rx_bit_valid <= 1'h0;
		rx_last <= 1'h0;
		rx_msu <= 1'h0;
	endtask
endmodule // dslc_peer

// File: testbench/dslc_ctrl_test.sv
// Purpose: self-checking bench for the label codec controller
// Assumes: ce held high except for the one register write in test_reset
// Notes: expected frames built here from field values
`timescale 1ns/1ps
`include "dslc_defines.svh"
module dslc_ctrl_test;
	logic        clk, sys_rst, ce, reg_wr, reg_rd, slow;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic        tx_ready, tx_bit, tx_bit_valid, tx_first, tx_last, tx_msu, rx_bit, rx_bit_valid, rx_last, rx_msu;
	logic [63:0] frame;
	logic [6:0]  frame_len;
	logic [7:0]  n_frames;
	int          n_mismatch;
	int          samples_checked;
	dslc_ctrl dslc_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_ready(tx_ready), .tx_bit(tx_bit),
		.tx_bit_valid(tx_bit_valid), .tx_first(tx_first), .tx_last(tx_last), .tx_msu(tx_msu), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .rx_last(rx_last), .rx_msu(rx_msu));
	dslc_peer dslc_peer_inst (.clk(clk), .sys_rst(sys_rst), .slow(slow), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
		.tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
		.rx_last(rx_last), .rx_msu(rx_msu), .frame(frame), .frame_len(frame_len), .n_frames(n_frames));
	always #2.5 clk = ~clk;
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic test_reset;
		logic [31:0] d;
		rd(`DSLC_A_STATUS, d);
		chk("status reset", 32'h0, d);
		rd(8'hFC, d);
		chk("unmapped read", 32'h0, d);
		wr(`DSLC_A_DEST, 32'hFFFFFFFF);
		rd(`DSLC_A_DEST, d);
		chk("dest width", 32'h3FFF, d);
		wr(`DSLC_A_DEST, 32'h2DA5);
		wr(`DSLC_A_ORIG, 32'h1B3C);
		wr(`DSLC_A_BEARER, 32'hA5C);
		wr(`DSLC_A_HEAD, 32'h96);
		ce <= 1'h0;
		wr(`DSLC_A_ORIG, 32'h0);
		ce <= 1'h1;
		rd(`DSLC_A_ORIG, d);
		chk("ce freeze", 32'h1B3C, d);
		$display("test reset done");
	endtask
	task automatic test_tx;
		logic [9:0]  ctl [5] = '{10'h029, 10'h011, 10'h015, 10'h003, 10'h081};
		logic [7:0]  slt [5] = '{8'h4F, 8'h4F, 8'h4F, 8'h4F, 8'h01};
		logic        sl [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
		logic [6:0]  len [5] = '{7'h40, 7'h3C, 7'h34, 7'h2C, 7'h3C};
		logic [63:0] ex [5];
		logic [7:0]  n0;
		ex[0] = {4'h9, 4'h6, 8'h4F, 12'hA5C, 14'h1B3C, 14'h2DA5, 8'h86};
		ex[1] = {4'h0, 4'h6, 8'h70, 12'hA5C, 14'h1B3C, 14'h2DA5, 8'h06};
		ex[2] = {12'h0, 4'h6, 12'hA5C, 14'h1B3C, 14'h2DA5, 8'h06};
		ex[3] = {20'h0, 4'h6, 4'hC, 14'h1B3C, 14'h2DA5, 8'h07};
		ex[4] = {4'h0, 4'h6, 8'h01, 12'hA5C, 14'h1B3C, 14'h2DA5, 8'h06};
		for (int i = 0; i < 5; i++)
		begin
			slow <= sl[i];
			wr(`DSLC_A_SLOT, {24'h0, slt[i]});
			n0 = n_frames;
			wr(`DSLC_A_CTRL, {22'h0, ctl[i]});
			for (int k = 0; k < 400 && n_frames == n0; k++)
				@(posedge clk);
			chk("tx frame", ex[i], frame);
			chk("tx length", {57'h0, len[i]}, {57'h0, frame_len});
		end
		$display("test tx done");
	endtask
	task automatic test_rx;
		logic [3:0]  hc [7] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'hF};
		logic [2:0]  kd [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h0};
		logic [7:0]  bad [3] = '{8'h46, 8'h05, 8'h86};
		logic [31:0] d;
		for (int i = 0; i < 7; i++)
		begin
			dslc_peer_inst.send({4'hA, hc[i], 8'h4F, 12'hA5C, 14'h1B3C, 14'h2DA5, 8'h86}, 64, 1'h1);
			rd(`DSLC_A_STATUS, d);
			chk("rx status", {kd[i], 2'h1}, d[6:2]);
			rd(`DSLC_A_RX_MISC, d);
			chk("rx misc", {8'h86, 4'h0, hc[i], 8'h4F}, d);
			rd(`DSLC_A_RX_DEST, d);
			chk("rx dest", 32'h2DA5, d);
			rd(`DSLC_A_RX_BEARER, d);
			chk("rx bearer", 32'hA5C, d);
		end
		rd(`DSLC_A_STATUS, d);
		chk("rx done clear", 1'h0, d[2]);
		for (int i = 0; i < 3; i++)
		begin
			dslc_peer_inst.send({4'h0, 4'h1, 8'h4F, 12'hA5C, 14'h1B3C, 14'h2DA5, bad[i]}, 60, i != 2);
			rd(`DSLC_A_STATUS, d);
			chk("rx error", 2'h3, d[3:2]);
		end
		$display("test rx done");
	endtask
	task automatic test_rx_alt;
		logic [31:0] d;
		wr(`DSLC_A_CTRL, 32'h300);
		dslc_peer_inst.send({8'h0, 4'h3, 4'h6, 12'h5A3, 14'h1B3C, 14'h2DA5, 8'h36}, 56, 1'h1);
		rd(`DSLC_A_STATUS, d);
		chk("rx alt status", 5'h11, d[6:2]);
		rd(`DSLC_A_RX_MISC, d);
		chk("rx alt misc", 32'h063670, d);
		rd(`DSLC_A_RX_BEARER, d);
		chk("rx alt code", 32'h5A3, d);
		rd(`DSLC_A_RX_ORIG, d);
		chk("rx orig", 32'h1B3C, d);
		dslc_peer_inst.send({16'h0, 4'h3, 4'h1, 4'hC, 14'h1B3C, 14'h2DA5, 8'h07}, 48, 1'h1);
		rd(`DSLC_A_RX_MISC, d);
		chk("rx facility misc", 32'h073100, d);
		rd(`DSLC_A_RX_BEARER, d);
		chk("rx facility bearer", 32'hC, d);
		$display("test rx alt done");
	endtask
	task automatic test_cfg;
		logic [9:0]  ctl [3] = '{10'h001, 10'h041, 10'h005};
		logic [7:0]  slt [3] = '{8'h50, 8'h04, 8'h00};
		logic [31:0] d;
		logic [7:0]  n0;
		for (int i = 0; i < 3; i++)
		begin
			wr(`DSLC_A_SLOT, {24'h0, slt[i]});
			n0 = n_frames;
			wr(`DSLC_A_CTRL, {22'h0, ctl[i]});
			repeat (20) @(posedge clk);
			rd(`DSLC_A_STATUS, d);
			chk("cfg error", 2'h2, d[1:0]);
			chk("no frame", n0, n_frames);
		end
		$display("test cfg done");
	endtask
	initial
	begin
		clk = 1'h0;
		sys_rst = 1'h1;
		ce = 1'h1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		slow = 1'h0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		test_reset;
		test_tx;
		test_rx;
		test_rx_alt;
		test_cfg;
		give_verdict;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		give_verdict;
	end
endmodule // dslc_ctrl_test
